// ### chsel_pkg.sv
// package: register map, field layout and select encodings for input selection
package chsel_pkg;

	// register byte addresses on the bus
	localparam logic [3:0] ADDR_GROUP_SEL = 4'h0;
	localparam logic [3:0] ADDR_ZERO_SEL  = 4'h4;
	localparam logic [3:0] ADDR_CTRL      = 4'h8;

	// field positions of the group and control registers
	localparam int POS_NEG_B  = 9;
	localparam int POS_POS_B  = 8;
	localparam int POS_NEG_A  = 1;
	localparam int POS_POS_A  = 0;
	localparam int POS_TWELVE = 0;
	localparam int POS_OPAMP  = 1;

	// writable masks and reset values
	localparam logic [15:0] MASK_GROUP = 16'h0707;
	localparam logic [15:0] MASK_ZERO  = 16'h001F;
	localparam logic [15:0] MASK_CTRL  = 16'h000F;
	localparam logic [15:0] RST_GROUP  = 16'h0000;
	localparam logic [15:0] RST_ZERO   = 16'h0000;
	localparam logic [15:0] RST_CTRL   = 16'h0000;

	// routed source codes toward the analog switches
	localparam logic [4:0] SRC_AN0      = 5'h00;
	localparam logic [4:0] SRC_AN_LAST  = 5'h0F;
	localparam logic [4:0] SRC_AMP1     = 5'h11;
	localparam logic [4:0] SRC_AMP2     = 5'h12;
	localparam logic [4:0] SRC_AMP3     = 5'h13;
	localparam logic [4:0] SRC_VREFL    = 5'h14;
	localparam logic [4:0] SRC_TEMP     = 5'h1E;
	localparam logic [4:0] SRC_OPEN     = 5'h1F;

	// channel zero selection codes
	localparam logic [4:0] CODE_AMP1 = 5'h18;
	localparam logic [4:0] CODE_AMP2 = 5'h19;
	localparam logic [4:0] CODE_AMP3 = 5'h1A;
	localparam logic [4:0] CODE_TEMP = 5'h1E;
	localparam logic [4:0] CODE_OPEN = 5'h1F;

	// negative select codes
	localparam logic [1:0] NEG_HIGH = 2'h3;
	localparam logic [1:0] NEG_MID  = 2'h2;

	// source selections for channels 1..3 of one multiplexer
	typedef struct packed {
		logic [4:0] ch1;
		logic [4:0] ch2;
		logic [4:0] ch3;
	} group_src_s;

	// bus request bundle
	typedef struct packed {
		logic        cyc;
		logic        stb;
		logic        we;
		logic [3:0]  adr;
		logic [1:0]  sel;
		logic [15:0] dat;
	} wb_req_s;

endpackage : chsel_pkg

// ### group_route.sv
// one channel 1..3 multiplexer route: negative and positive selects to source codes
`timescale 1ns/1ps
module group_route (
	input  wire logic                  twelve,
	input  wire logic [2:0]            amp_on,
	input  wire logic [1:0]            neg_sel,
	input  wire logic                  pos_sel,
	output chsel_pkg::group_src_s      neg_src,
	output chsel_pkg::group_src_s      pos_src
);
	import chsel_pkg::*;

	// combined sources pick the amplifier when its op-amp mode bit is set
	function automatic logic [4:0] combo(input logic on, input logic [4:0] amp,
		input logic [4:0] pin);
		combo = on ? amp : pin;
	endfunction : combo

	// negative and positive decode; twelve-bit mode forces the field as zero
	always_comb begin
		neg_src = '{SRC_VREFL, SRC_VREFL, SRC_VREFL};
		pos_src = '{combo(amp_on[1], SRC_AMP2, 5'h00), 5'h01, 5'h02};
		if (!twelve) begin
			if (neg_sel == NEG_HIGH) begin
				neg_src = '{5'h09, 5'h0A, 5'h0B};
			end else if (neg_sel == NEG_MID) begin
				neg_src = '{combo(amp_on[2], SRC_AMP3, 5'h06), 5'h07, 5'h08};
			end
			if (pos_sel) begin
				pos_src = '{combo(amp_on[0], SRC_AMP1, 5'h03),
					combo(amp_on[1], SRC_AMP2, 5'h00),
					combo(amp_on[2], SRC_AMP3, 5'h06)};
			end
		end
	end

endmodule : group_route

// ### zero_route.sv
// channel zero positive decode onto source codes
`timescale 1ns/1ps
module zero_route (
	input  wire logic [2:0] amp_on,
	input  wire logic [4:0] code,
	output logic      [4:0] src
);
	import chsel_pkg::*;

	// reserved codes fall back to open, the safest analog state
	always_comb begin
		src = SRC_OPEN;
		if (code <= SRC_AN_LAST) begin
			src = code;
		end else if (code == CODE_AMP1) begin
			src = amp_on[0] ? SRC_AMP1 : 5'h03;
		end else if (code == CODE_AMP2) begin
			src = amp_on[1] ? SRC_AMP2 : 5'h00;
		end else if (code == CODE_AMP3) begin
			src = amp_on[2] ? SRC_AMP3 : 5'h06;
		end else if (code == CODE_TEMP) begin
			src = SRC_TEMP;
		end
	end

endmodule : zero_route

// ### adc_input_channel_select.sv
// top: wishbone register file and input routing for the converter sample channels
//
// Design decisions made here: the register addresses and the Wishbone interface to the registers.
`timescale 1ns/1ps
module adc_input_channel_select (
	input  wire logic                  MCLK,
	input  wire logic                  RST_B,
	input  wire logic                  WB_CYC_I,
	input  wire logic                  WB_STB_I,
	input  wire logic                  WB_WE_I,
	input  wire logic [3:0]            WB_ADR_I,
	input  wire logic [1:0]            WB_SEL_I,
	input  wire logic [15:0]           WB_DAT_I,
	output logic      [15:0]           WB_DAT_O,
	output logic                       WB_ACK_O,
	output chsel_pkg::group_src_s      NEG_A_SRC,
	output chsel_pkg::group_src_s      POS_A_SRC,
	output chsel_pkg::group_src_s      NEG_B_SRC,
	output chsel_pkg::group_src_s      POS_B_SRC,
	output logic      [4:0]            ZERO_SRC
);
	import chsel_pkg::*;

	wb_req_s     req;
	logic [15:0] group_r;
	logic [15:0] zero_r;
	logic [15:0] ctrl_r;
	logic        ack_r;
	logic [15:0] rd_nxt;
	logic [15:0] lane;
	logic        hit;
	logic        wr_go;
	logic        twelve;
	logic [2:0]  amp_on;
	group_src_s  na;
	group_src_s  pa;
	group_src_s  nb;
	group_src_s  pb;
	logic [4:0]  zs;

	////////////////////////////////////////////////////////////////////////////////
	// bus decode

	// bundle the request so the decode reads one place
	assign req  = '{WB_CYC_I, WB_STB_I, WB_WE_I, WB_ADR_I, WB_SEL_I, WB_DAT_I};
	assign hit  = req.cyc && req.stb && !ack_r;
	// the master still holds the request at the ack edge, so the write lands there
	assign wr_go = ack_r && req.cyc && req.stb && req.we;
	assign lane = {{8{req.sel[1]}}, {8{req.sel[0]}}};

	// one wait-free ack, dropped the cycle after so back-to-back strobes still pair
	always_ff @(posedge MCLK or negedge RST_B) begin
		if (!RST_B) begin
			ack_r <= 1'b0;
		end else begin
			ack_r <= hit;
		end
	end
	assign WB_ACK_O = ack_r;

	// writes land at the ack edge; unmapped addresses are acked and ignored
	always_ff @(posedge MCLK or negedge RST_B) begin
		if (!RST_B) begin
			group_r <= RST_GROUP;
			zero_r  <= RST_ZERO;
			ctrl_r  <= RST_CTRL;
		end else if (wr_go) begin
			if (req.adr == ADDR_GROUP_SEL) begin
				group_r <= (group_r & ~lane) | (req.dat & lane & MASK_GROUP);
			end
			if (req.adr == ADDR_ZERO_SEL) begin
				zero_r <= (zero_r & ~lane) | (req.dat & lane & MASK_ZERO);
			end
			if (req.adr == ADDR_CTRL) begin
				ctrl_r <= (ctrl_r & ~lane) | (req.dat & lane & MASK_CTRL);
			end
		end
	end

	assign twelve = ctrl_r[POS_TWELVE];
	assign amp_on = ctrl_r[POS_OPAMP +: 3];

	// read mux; group fields above bit 0 vanish in twelve-bit mode
	always_comb begin
		rd_nxt = 16'h0000;
		unique case (req.adr)
			ADDR_GROUP_SEL: rd_nxt = twelve ? (group_r & 16'h0001) : group_r;
			ADDR_ZERO_SEL:  rd_nxt = zero_r;
			ADDR_CTRL:      rd_nxt = ctrl_r;
			default:        rd_nxt = 16'h0000;
		endcase
	end

	// read data registered with the ack
	always_ff @(posedge MCLK or negedge RST_B) begin
		if (!RST_B) begin
			WB_DAT_O <= 16'h0000;
		end else if (hit) begin
			WB_DAT_O <= rd_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// routing

	group_route u_mux_a (
		.twelve  (twelve),
		.amp_on  (amp_on),
		.neg_sel (group_r[POS_NEG_A +: 2]),
		.pos_sel (1'b0),
		.neg_src (na),
		.pos_src (pa)
	);

	group_route u_mux_b (
		.twelve  (twelve),
		.amp_on  (amp_on),
		.neg_sel (group_r[POS_NEG_B +: 2]),
		.pos_sel (group_r[POS_POS_B]),
		.neg_src (nb),
		.pos_src (pb)
	);

	zero_route u_zero (
		.amp_on (amp_on),
		.code   (zero_r[4:0]),
		.src    (zs)
	);

	// selects go out registered so the switches never see decode glitches
	always_ff @(posedge MCLK or negedge RST_B) begin
		if (!RST_B) begin
			NEG_A_SRC <= '{SRC_VREFL, SRC_VREFL, SRC_VREFL};
			POS_A_SRC <= '{SRC_AN0, 5'h01, 5'h02};
			NEG_B_SRC <= '{SRC_VREFL, SRC_VREFL, SRC_VREFL};
			POS_B_SRC <= '{SRC_AN0, 5'h01, 5'h02};
			ZERO_SRC  <= SRC_AN0;
		end else begin
			NEG_A_SRC <= na;
			POS_A_SRC <= pa;
			NEG_B_SRC <= nb;
			POS_B_SRC <= pb;
			ZERO_SRC  <= zs;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// assertions

	AST_GROUP_HIGH_ZERO: assert property (@(posedge MCLK) disable iff (!RST_B)
		(group_r[15:11] == 5'h00)) else $error("group high bits set");

	AST_GROUP_MID_ZERO: assert property (@(posedge MCLK) disable iff (!RST_B)
		(group_r[7:3] == 5'h00)) else $error("group middle bits set");

	AST_TWELVE_READ: assert property (@(posedge MCLK) disable iff (!RST_B)
		(hit && !req.we && req.adr == ADDR_GROUP_SEL && twelve)
		|=> (WB_DAT_O[10:1] == 10'h000 && WB_ACK_O)) else $error("twelve-bit read not zero");

	AST_NEG_B_HIGH: assert property (@(posedge MCLK) disable iff (!RST_B)
		(!twelve && group_r[10:9] == NEG_HIGH) |=> (NEG_B_SRC.ch3 == 5'h0B))
		else $error("b negative high wrong");

	AST_NEG_A_LOW: assert property (@(posedge MCLK) disable iff (!RST_B)
		(group_r[2] == 1'b0) |=> (NEG_A_SRC.ch1 == SRC_VREFL))
		else $error("a negative low not reference");

	AST_POS_B_SET: assert property (@(posedge MCLK) disable iff (!RST_B)
		(!twelve && group_r[8] && !amp_on[0]) |=> (POS_B_SRC.ch1 == 5'h03))
		else $error("b positive set wrong");

	AST_AMP_ROUTE: assert property (@(posedge MCLK) disable iff (!RST_B)
		(zero_r[4:0] == CODE_AMP3 && amp_on[2]) |=> (ZERO_SRC == SRC_AMP3))
		else $error("amplifier not routed");

	AST_ZERO_PIN: assert property (@(posedge MCLK) disable iff (!RST_B)
		(zero_r[4] == 1'b0) |=> (ZERO_SRC == $past(zero_r[4:0])))
		else $error("channel zero pin wrong");

	AST_ZERO_TEMP: assert property (@(posedge MCLK) disable iff (!RST_B)
		(zero_r[4:0] == CODE_TEMP) |=> (ZERO_SRC == SRC_TEMP))
		else $error("temperature not routed");

	AST_ZERO_OPEN: assert property (@(posedge MCLK) disable iff (!RST_B)
		(zero_r[4:0] == CODE_OPEN) |=> (ZERO_SRC == SRC_OPEN))
		else $error("channel zero not open");

	AST_ACK_ONE: assert property (@(posedge MCLK) disable iff (!RST_B)
		WB_ACK_O |=> !WB_ACK_O) else $error("ack held two cycles");

	////////////////////////////////////////////////////////////////////////////////
	// assertions: bus side
	// every take answers one cycle later, and nothing else answers

	AST_ACK_AFTER_TAKE: assert property (@(posedge MCLK) disable iff (!RST_B)
		hit |=> WB_ACK_O)
		else $error("take without ack");

	AST_NO_ACK_IDLE: assert property (@(posedge MCLK) disable iff (!RST_B)
		!hit |=> !WB_ACK_O)
		else $error("ack without take");

	AST_DAT_HOLD: assert property (@(posedge MCLK) disable iff (!RST_B)
		!hit |=> $stable(WB_DAT_O))
		else $error("read data moved without take");

	// write landing and masking; a partial lane write is left to the bench
	AST_WRITE_GROUP: assert property (@(posedge MCLK) disable iff (!RST_B)
		(wr_go && req.adr == ADDR_GROUP_SEL && req.sel == 2'h3)
		|=> (group_r == ($past(req.dat) & MASK_GROUP)))
		else $error("group write wrong");

	AST_WRITE_ZERO: assert property (@(posedge MCLK) disable iff (!RST_B)
		(wr_go && req.adr == ADDR_ZERO_SEL && req.sel == 2'h3)
		|=> (zero_r == ($past(req.dat) & MASK_ZERO)))
		else $error("zero write wrong");

	AST_WRITE_CTRL: assert property (@(posedge MCLK) disable iff (!RST_B)
		(wr_go && req.adr == ADDR_CTRL && req.sel == 2'h3)
		|=> (ctrl_r == ($past(req.dat) & MASK_CTRL)))
		else $error("control write wrong");

	AST_STABLE_GROUP: assert property (@(posedge MCLK) disable iff (!RST_B)
		!wr_go |=> $stable(group_r))
		else $error("group changed without write");

	AST_STABLE_ZERO: assert property (@(posedge MCLK) disable iff (!RST_B)
		!wr_go |=> $stable(zero_r))
		else $error("zero changed without write");

	AST_STABLE_CTRL: assert property (@(posedge MCLK) disable iff (!RST_B)
		!wr_go |=> $stable(ctrl_r))
		else $error("control changed without write");

	AST_ZERO_HIGH_ZERO: assert property (@(posedge MCLK) disable iff (!RST_B)
		(zero_r[15:5] == 11'h000))
		else $error("zero high bits set");

	AST_CTRL_HIGH_ZERO: assert property (@(posedge MCLK) disable iff (!RST_B)
		(ctrl_r[15:4] == 12'h000))
		else $error("control high bits set");

	// read data follows the register sampled at the take edge
	AST_READ_GROUP: assert property (@(posedge MCLK) disable iff (!RST_B)
		(hit && req.adr == ADDR_GROUP_SEL && !twelve) |=> (WB_DAT_O == $past(group_r)))
		else $error("group read wrong");

	AST_READ_HIGH_ZERO: assert property (@(posedge MCLK) disable iff (!RST_B)
		(hit && req.adr == ADDR_GROUP_SEL) |=> (WB_DAT_O[15:11] == 5'h00))
		else $error("group read high bits set");

	AST_READ_MID_ZERO: assert property (@(posedge MCLK) disable iff (!RST_B)
		(hit && req.adr == ADDR_GROUP_SEL) |=> (WB_DAT_O[7:3] == 5'h00))
		else $error("group read middle bits set");

	AST_READ_ZERO: assert property (@(posedge MCLK) disable iff (!RST_B)
		(hit && req.adr == ADDR_ZERO_SEL) |=> (WB_DAT_O == $past(zero_r)))
		else $error("zero read wrong");

	AST_READ_CTRL: assert property (@(posedge MCLK) disable iff (!RST_B)
		(hit && req.adr == ADDR_CTRL) |=> (WB_DAT_O == $past(ctrl_r)))
		else $error("control read wrong");

	AST_READ_UNMAPPED: assert property (@(posedge MCLK) disable iff (!RST_B)
		(hit && req.adr != ADDR_GROUP_SEL && req.adr != ADDR_ZERO_SEL && req.adr != ADDR_CTRL)
		|=> (WB_DAT_O == 16'h0000))
		else $error("unmapped read not zero");

	////////////////////////////////////////////////////////////////////////////////
	// assertions: routing side
	// each route lags its register by one cycle, so every check but AST_POS_A_FIXED and AST_ZERO_LEGAL looks one edge on

	AST_NEG_B_MID: assert property (@(posedge MCLK) disable iff (!RST_B)
		(!twelve && group_r[10:9] == NEG_MID)
		|=> (NEG_B_SRC.ch2 == 5'h07 && NEG_B_SRC.ch3 == 5'h08))
		else $error("b negative mid wrong");

	AST_NEG_B_LOW: assert property (@(posedge MCLK) disable iff (!RST_B)
		(group_r[10] == 1'b0) |=> (NEG_B_SRC.ch1 == SRC_VREFL
		&& NEG_B_SRC.ch2 == SRC_VREFL && NEG_B_SRC.ch3 == SRC_VREFL))
		else $error("b negative low not reference");

	AST_NEG_B_AMP: assert property (@(posedge MCLK) disable iff (!RST_B)
		(!twelve && group_r[10:9] == NEG_MID && amp_on[2]) |=> (NEG_B_SRC.ch1 == SRC_AMP3))
		else $error("b negative amplifier not routed");

	AST_NEG_B_PIN: assert property (@(posedge MCLK) disable iff (!RST_B)
		(!twelve && group_r[10:9] == NEG_MID && !amp_on[2]) |=> (NEG_B_SRC.ch1 == 5'h06))
		else $error("b negative pin not routed");

	AST_NEG_A_HIGH: assert property (@(posedge MCLK) disable iff (!RST_B)
		(!twelve && group_r[2:1] == NEG_HIGH) |=> (NEG_A_SRC.ch1 == 5'h09
		&& NEG_A_SRC.ch2 == 5'h0A && NEG_A_SRC.ch3 == 5'h0B))
		else $error("a negative high wrong");

	AST_NEG_A_MID: assert property (@(posedge MCLK) disable iff (!RST_B)
		(!twelve && group_r[2:1] == NEG_MID)
		|=> (NEG_A_SRC.ch2 == 5'h07 && NEG_A_SRC.ch3 == 5'h08))
		else $error("a negative mid wrong");

	AST_NEG_A_AMP: assert property (@(posedge MCLK) disable iff (!RST_B)
		(!twelve && group_r[2:1] == NEG_MID && amp_on[2]) |=> (NEG_A_SRC.ch1 == SRC_AMP3))
		else $error("a negative amplifier not routed");

	AST_POS_B_CLEAR: assert property (@(posedge MCLK) disable iff (!RST_B)
		(!group_r[8] || twelve) |=> (POS_B_SRC.ch2 == 5'h01 && POS_B_SRC.ch3 == 5'h02))
		else $error("b positive clear wrong");

	AST_POS_B_CLEAR_AMP: assert property (@(posedge MCLK) disable iff (!RST_B)
		((!group_r[8] || twelve) && amp_on[1]) |=> (POS_B_SRC.ch1 == SRC_AMP2))
		else $error("b positive clear amplifier not routed");

	AST_POS_B_SET_AMP: assert property (@(posedge MCLK) disable iff (!RST_B)
		(!twelve && group_r[8] && amp_on[1] && amp_on[2])
		|=> (POS_B_SRC.ch2 == SRC_AMP2 && POS_B_SRC.ch3 == SRC_AMP3))
		else $error("b positive set amplifiers not routed");

	AST_POS_A_FIXED: assert property (@(posedge MCLK) disable iff (!RST_B)
		(POS_A_SRC.ch2 == 5'h01 && POS_A_SRC.ch3 == 5'h02))
		else $error("a positive moved");

	AST_POS_A_AMP: assert property (@(posedge MCLK) disable iff (!RST_B)
		amp_on[1] |=> (POS_A_SRC.ch1 == SRC_AMP2))
		else $error("a positive amplifier not routed");

	// twelve-bit mode routes as if every group field were zero
	AST_TWELVE_NEG: assert property (@(posedge MCLK) disable iff (!RST_B)
		twelve |=> (NEG_A_SRC.ch1 == SRC_VREFL && NEG_B_SRC.ch1 == SRC_VREFL))
		else $error("twelve-bit negative not reference");

	AST_TWELVE_POS: assert property (@(posedge MCLK) disable iff (!RST_B)
		twelve |=> (POS_B_SRC.ch2 == 5'h01 && POS_B_SRC.ch3 == 5'h02))
		else $error("twelve-bit positive not clear");

	AST_ZERO_AMP1: assert property (@(posedge MCLK) disable iff (!RST_B)
		(zero_r[4:0] == CODE_AMP1 && amp_on[0]) |=> (ZERO_SRC == SRC_AMP1))
		else $error("channel zero amplifier one wrong");

	AST_ZERO_AMP1_PIN: assert property (@(posedge MCLK) disable iff (!RST_B)
		(zero_r[4:0] == CODE_AMP1 && !amp_on[0]) |=> (ZERO_SRC == 5'h03))
		else $error("channel zero pin three wrong");

	AST_ZERO_AMP2: assert property (@(posedge MCLK) disable iff (!RST_B)
		(zero_r[4:0] == CODE_AMP2 && amp_on[1]) |=> (ZERO_SRC == SRC_AMP2))
		else $error("channel zero amplifier two wrong");

	AST_ZERO_AMP2_PIN: assert property (@(posedge MCLK) disable iff (!RST_B)
		(zero_r[4:0] == CODE_AMP2 && !amp_on[1]) |=> (ZERO_SRC == 5'h00))
		else $error("channel zero pin zero wrong");

	AST_ZERO_AMP3_PIN: assert property (@(posedge MCLK) disable iff (!RST_B)
		(zero_r[4:0] == CODE_AMP3 && !amp_on[2]) |=> (ZERO_SRC == 5'h06))
		else $error("channel zero pin six wrong");

	// no legal code may ever put a reference or unknown source on channel zero
	AST_ZERO_LEGAL: assert property (@(posedge MCLK) disable iff (!RST_B)
		((ZERO_SRC <= SRC_AMP3 && ZERO_SRC != 5'h10) || ZERO_SRC >= SRC_TEMP))
		else $error("channel zero source illegal");

	AST_ZERO_STABLE: assert property (@(posedge MCLK) disable iff (!RST_B)
		($stable(zero_r) && $stable(ctrl_r)) |=> $stable(ZERO_SRC))
		else $error("channel zero moved without a write");

endmodule : adc_input_channel_select

// ### analog_mux_model.sv
// partner: analog switch bank giving the level seen on the channel zero sample input
`timescale 1ns/1ps
module analog_mux_model (
	input  wire logic [4:0] src,
	output logic      [7:0] level
);
	//////////////////////////////////////////////////////////////////////////
	// every source carries its own level; an open node floats, so it shows a
	// level that no real source gives instead of a value the simulator settles
	always_comb begin
		if (src == 5'h1F)
			level = 8'hFF;
		else
			level = {3'h0, src} ^ 8'h5A;
	end
endmodule : analog_mux_model

// ### tb.sv
// testbench: wishbone register access and input routing checks
`timescale 1ns/1ps
module tb;
	import chsel_pkg::*;
	logic        MCLK = 1'b0, RST_B = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0, ack;
	logic [3:0]  adr  = 4'h0;
	logic [1:0]  sel  = 2'h0;
	logic [15:0] wdat = 16'h0000, rdat, dat_o, d;
	logic [4:0]  zsrc, ze;
	logic [7:0]  zlvl;
	logic [2:0]  amp  = 3'h0;
	group_src_s  neg_a, pos_a, neg_b, pos_b;
	int          bad_count = 0, tests_run = 0;

	always #5 MCLK = ~MCLK;

	adc_input_channel_select dut_u (.MCLK(MCLK), .RST_B(RST_B), .WB_CYC_I(cyc), .WB_STB_I(stb),
		.WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wdat), .WB_DAT_O(dat_o),
		.WB_ACK_O(ack), .NEG_A_SRC(neg_a), .POS_A_SRC(pos_a), .NEG_B_SRC(neg_b),
		.POS_B_SRC(pos_b), .ZERO_SRC(zsrc));
	analog_mux_model mux_u (.src(zsrc), .level(zlvl));

	//////////////////////////////////////////////////////////////////////////
	task automatic end_sim;
		if (bad_count == 0 && tests_run > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask : end_sim

	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		tests_run++;
		if (g !== e) begin
			bad_count++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	// one classic cycle; a missing ack ends the run rather than hanging it
	task automatic wb(input logic w, input logic [3:0] a, input logic [1:0] s, input logic [15:0] dw);
		int n;
		n = 0;
		@(posedge MCLK);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		sel <= s;
		wdat <= dw;
		do begin
			@(posedge MCLK);
			n++;
		end while (ack !== 1'b1 && n < 20);
		rdat = dat_o;
		cyc <= 1'b0;
		stb <= 1'b0;
		if (ack !== 1'b1) begin
			chk("ack", 16'h0001, {15'h0000, ack});
			end_sim();
		end
	endtask : wb

	// amplifier k output when its op-amp mode bit is set, else its shared pin
	function automatic logic [4:0] am(input logic [1:0] k);
		case (k)
			2'h1: am = amp[0] ? SRC_AMP1 : 5'h03;
			2'h2: am = amp[1] ? SRC_AMP2 : 5'h00;
			default: am = amp[2] ? SRC_AMP3 : 5'h06;
		endcase
	endfunction : am

	function automatic group_src_s ne(input logic [1:0] c);
		if (c == NEG_HIGH) ne = {5'h09, 5'h0A, 5'h0B};
		else if (c == NEG_MID) ne = {am(2'h3), 5'h07, 5'h08};
		else ne = {SRC_VREFL, SRC_VREFL, SRC_VREFL};
	endfunction : ne

	// routes settle one cycle after the register, so look two edges on
	task automatic routes(input logic [1:0] na, input logic [1:0] nb, input logic pb);
		repeat (2) @(posedge MCLK);
		chk("neg_a", {1'b0, ne(na)}, {1'b0, neg_a});
		chk("neg_b", {1'b0, ne(nb)}, {1'b0, neg_b});
		chk("pos_b", {1'b0, pb ? {am(2'h1), am(2'h2), am(2'h3)} : {am(2'h2), 5'h01, 5'h02}},
			{1'b0, pos_b});
		chk("pos_a", {1'b0, am(2'h2), 5'h01, 5'h02}, {1'b0, pos_a});
	endtask : routes

	//////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (12) @(posedge MCLK);
		RST_B <= 1'b1;
		routes(2'h0, 2'h0, 1'b0);
		wb(1'b1, ADDR_GROUP_SEL, 2'h3, 16'hFFFF);
		wb(1'b0, ADDR_GROUP_SEL, 2'h3, 16'h0000);
		chk("group ones", 16'h0707, rdat);
		for (int k = 0; k < 3; k++) begin
			amp = 3'(k * 3);
			wb(1'b1, ADDR_CTRL, 2'h3, {12'h000, amp, 1'b0});
			for (int c = 0; c < 4; c++) begin
				d = {5'h00, 2'(c), c[0], 5'h00, 2'(3 - c), c[1]};
				wb(1'b1, ADDR_GROUP_SEL, 2'h3, d);
				wb(1'b0, ADDR_GROUP_SEL, 2'h3, 16'h0000);
				chk("group", d, rdat);
				routes(2'(3 - c), 2'(c), c[0]);
			end
			// reserved channel zero codes are never written
			for (int c = 0; c < 32; c++) begin
				if ((c > 15 && c < 24) || (c > 26 && c < 30)) continue;
				wb(1'b1, ADDR_ZERO_SEL, 2'h3, 16'(c));
				wb(1'b0, ADDR_ZERO_SEL, 2'h3, 16'h0000);
				chk("zero read", 16'(c), rdat);
				ze = c < 16 ? 5'(c) : c < 27 ? am(2'(c - 23)) : c == 30 ? SRC_TEMP : SRC_OPEN;
				repeat (2) @(posedge MCLK);
				chk("zero_src", {11'h000, ze}, {11'h000, zsrc});
				chk("zero level", {8'h00, ze == SRC_OPEN ? 8'hFF : {3'h0, ze} ^ 8'h5A},
					{8'h00, zlvl});
			end
		end
		// twelve-bit mode hides the group fields above bit 0 but keeps what was stored
		wb(1'b1, ADDR_GROUP_SEL, 2'h3, 16'h0707);
		wb(1'b1, ADDR_CTRL, 2'h3, {12'h000, amp, 1'b1});
		wb(1'b0, ADDR_GROUP_SEL, 2'h3, 16'h0000);
		chk("group twelve", 16'h0001, rdat);
		routes(2'h0, 2'h0, 1'b0);
		wb(1'b1, ADDR_CTRL, 2'h3, 16'h0000);
		wb(1'b0, ADDR_GROUP_SEL, 2'h3, 16'h0000);
		chk("group back", 16'h0707, rdat);
		// low byte lane only, then an unmapped place
		wb(1'b1, ADDR_GROUP_SEL, 2'h3, 16'h0000);
		wb(1'b1, ADDR_GROUP_SEL, 2'h1, 16'hFFFF);
		wb(1'b1, 4'hC, 2'h3, 16'hFFFF);
		wb(1'b0, 4'hC, 2'h3, 16'h0000);
		chk("unmapped", 16'h0000, rdat);
		wb(1'b0, ADDR_GROUP_SEL, 2'h3, 16'h0000);
		chk("group lane", 16'h0007, rdat);
		end_sim();
	end
endmodule : tb
